// ### dcff_pkg.sv
package dcff_pkg;

  // ---------------------------------------------------------------
  // sizes and defaults
  // ---------------------------------------------------------------
  localparam int          DATA_W         = 18;
  localparam int          DEPTH_DEF      = 32768;
  localparam logic [15:0] OFS_SERIAL_DEF = 16'h03ff;
  localparam logic [15:0] OFS_PAR_DEF    = 16'h007f;

  // ---------------------------------------------------------------
  // flag register depths, counted in link clock edges
  // ---------------------------------------------------------------
  localparam int EMPTY_STAGES = 2;
  localparam int OR_STAGES    = 3;
  localparam int FULL_STAGES  = 2;

  typedef enum logic {
    DCFF_STD  = 1'b0,
    DCFF_FWFT = 1'b1
  } dcff_mode_t;

  typedef struct packed {
    logic full_flag_n;
    logic almost_full_flag_n;
    logic half_full_flag_n;
    logic almost_empty_flag_n;
    logic empty_flag_n;
  } dcff_flags_t;

  typedef struct packed {
    logic wclk;
    logic rclk;
    logic wen_n;
    logic ren_n;
    logic master_reset_n;
    logic fwft_si;
    logic offset_load_n;
    logic serial_en_n;
  } dcff_ctl_t;

endpackage

// ### dcff_sync.sv
`timescale 1ns/100ps

module dcff_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;

  // stage1 feeds only the second flop
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule // dcff_sync

// ### dcff_core.sv
`timescale 1ns/100ps

// Operation
// - mode pin latched during master reset
// - fall-through: first word out after three edges
// - write enable low stores word per edge
// - standard: empty flag rises after first write
// - standard: almost-empty high above offset n
// - standard: half-full low at half plus one
// - standard: almost-full low at depth minus m
// - standard: full low at depth, writes ignored
// - standard: read from full releases full
// - read ignored when empty; empty flag drops
// - empty/full two stages, output-ready three
// - fall-through: almost-empty high at n plus two
// - fall-through: half-full low at half plus two
// - fall-through: almost-full low at depth+1-m
// - fall-through: input-ready blocks at depth plus one
// - fall-through: read from full frees input
// - fall-through: output-ready high after last read
// - load high at reset: serial, offsets 3ff
// - load low at reset: parallel, offsets 07f
// - offsets read back in both serial and parallel modes
// - offsets programmable any time after reset
module dcff_core
  import dcff_pkg::*;
#(
  parameter int DEPTH = dcff_pkg::DEPTH_DEF
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  input  wire logic                      wclk,
  input  wire logic                      rclk,
  input  wire logic                      wen_n,
  input  wire logic                      ren_n,
  input  wire logic                      master_reset_n,
  input  wire logic                      fwft_si,
  input  wire logic                      offset_load_n,
  input  wire logic                      serial_en_n,
  input  wire logic [dcff_pkg::DATA_W-1:0] data_in,
  output logic      [dcff_pkg::DATA_W-1:0] read_data_out,
  output dcff_pkg::dcff_flags_t          flags
);
  import dcff_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 2;
  localparam logic [CW-1:0] DEP  = CW'(DEPTH);
  localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);

  function automatic logic [CW-1:0] ext(input logic [AW-1:0] v);
    ext = {2'b00, v};
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers and link clock edges
  // ---------------------------------------------------------------
  dcff_ctl_t         cs;
  logic [DATA_W-1:0] din_s;

  dcff_sync #(
    .W ($bits(dcff_ctl_t) + DATA_W)
  ) u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     ({wclk, rclk, wen_n, ren_n, master_reset_n, fwft_si,
             offset_load_n, serial_en_n, data_in}),
    .q     ({cs, din_s})
  );

  logic wclk_d;
  logic rclk_d;
  logic wedge;
  logic redge;
  logic mrs_act;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
    end else begin
      wclk_d <= cs.wclk;
      rclk_d <= cs.rclk;
    end
  end

  assign wedge   = cs.wclk & ~wclk_d;
  assign redge   = cs.rclk & ~rclk_d;
  assign mrs_act = ~cs.master_reset_n;

  // ---------------------------------------------------------------
  // storage state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0]   mem [DEPTH];
  dcff_mode_t          mode, next_mode;
  logic                serial_mode, next_serial_mode;
  logic [AW-1:0]       wptr, next_wptr;
  logic [AW-1:0]       rptr, next_rptr;
  logic [AW:0]         mem_cnt, next_mem_cnt;
  logic                ov, next_ov;
  logic [AW-1:0]       ofs_e, next_ofs_e;
  logic [AW-1:0]       ofs_f, next_ofs_f;
  logic                wr_sel, next_wr_sel;
  logic                rd_sel, next_rd_sel;
  logic [1:0]          empty_pipe, next_empty_pipe;
  logic [1:0]          full_pipe, next_full_pipe;
  logic [DATA_W-1:0]   next_rdata;
  dcff_flags_t         next_flags;

  logic          full_mem;
  logic          fwft;
  logic          do_wr;
  logic          rd_std;
  logic          fw_fill;
  logic          fw_drain;
  logic          mem_rd;
  logic          ofs_pwr;
  logic          ofs_ser;
  logic          ofs_prd;
  logic [CW-1:0] tot;
  logic [CW-1:0] adj;
  logic          full_raw;

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  always_comb begin
    fwft     = (mode == DCFF_FWFT);
    full_mem = ({1'b0, mem_cnt} == DEP[AW+1:0]);
    // writes stop at a full array, which in fall-through is depth+1
    // words once the output register is counted
    do_wr    = wedge & ~cs.wen_n & cs.offset_load_n & ~full_mem
               & ~mrs_act;
    ofs_pwr  = wedge & ~cs.wen_n & ~cs.offset_load_n & ~serial_mode
               & ~mrs_act;
    ofs_ser  = wedge & cs.wen_n & ~cs.offset_load_n & ~cs.serial_en_n
               & serial_mode & ~mrs_act;
    ofs_prd  = redge & ~cs.ren_n & ~cs.offset_load_n & ~mrs_act;
    // an empty array never moves the read pointer
    rd_std   = redge & ~cs.ren_n & cs.offset_load_n & ~fwft
               & (mem_cnt != '0) & ~mrs_act;
    // third rclk edge after the word arrives loads the output register
    fw_fill  = redge & fwft & empty_pipe[1] & (mem_cnt != '0) & ~mrs_act
               & (~ov | (~cs.ren_n & cs.offset_load_n));
    fw_drain = redge & fwft & ov & ~cs.ren_n & cs.offset_load_n
               & ~fw_fill & ~mrs_act;
    mem_rd   = rd_std | fw_fill;
    tot      = CW'(mem_cnt) + CW'(ov);
    adj      = CW'(fwft);
    full_raw = fwft ? (tot == DEP + CW'(1)) : full_mem;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_mode        = mode;
    next_serial_mode = serial_mode;
    next_wptr        = wptr;
    next_rptr        = rptr;
    next_mem_cnt     = mem_cnt;
    next_ov          = ov;
    next_ofs_e       = ofs_e;
    next_ofs_f       = ofs_f;
    next_wr_sel      = wr_sel;
    next_rd_sel      = rd_sel;
    next_empty_pipe  = empty_pipe;
    next_full_pipe   = full_pipe;
    next_rdata       = read_data_out;
    if (mrs_act) begin
      next_mode        = dcff_mode_t'(cs.fwft_si);
      next_serial_mode = cs.offset_load_n;
      next_wptr        = '0;
      next_rptr        = '0;
      next_mem_cnt     = '0;
      next_ov          = 1'b0;
      next_wr_sel      = 1'b0;
      next_rd_sel      = 1'b0;
      next_empty_pipe  = 2'h0;
      next_full_pipe   = 2'h0;
      next_rdata       = '0;
      if (cs.offset_load_n) begin
        next_ofs_e = OFS_SERIAL_DEF[AW-1:0];
        next_ofs_f = OFS_SERIAL_DEF[AW-1:0];
      end else begin
        next_ofs_e = OFS_PAR_DEF[AW-1:0];
        next_ofs_f = OFS_PAR_DEF[AW-1:0];
      end
    end else begin
      if (do_wr) begin
        next_wptr = wptr + AW'(1);
      end
      if (mem_rd) begin
        next_rptr  = rptr + AW'(1);
        next_rdata = mem[rptr];
      end
      next_mem_cnt = mem_cnt + (AW+1)'(do_wr) - (AW+1)'(mem_rd);
      if (fw_fill) begin
        next_ov = 1'b1;
      end else if (fw_drain) begin
        next_ov = 1'b0;
      end
      // parallel load alternates empty then full offset
      if (ofs_pwr) begin
        if (wr_sel) begin
          next_ofs_f = din_s[AW-1:0];
        end else begin
          next_ofs_e = din_s[AW-1:0];
        end
        next_wr_sel = ~wr_sel;
      end
      // serial: empty offset lsb enters first, full offset msb last
      if (ofs_ser) begin
        {next_ofs_f, next_ofs_e} = {cs.fwft_si, ofs_f, ofs_e[AW-1:1]};
      end
      // readback works in both serial and parallel modes
      if (ofs_prd) begin
        next_rdata  = DATA_W'(rd_sel ? ofs_f : ofs_e);
        next_rd_sel = ~rd_sel;
      end
      if (redge) begin
        next_empty_pipe = {empty_pipe[0], mem_cnt != '0};
      end
      if (wedge) begin
        next_full_pipe = {full_pipe[0], full_raw};
      end
    end
  end

  // ---------------------------------------------------------------
  // flags, compared on the total held including the output word
  // ---------------------------------------------------------------
  always_comb begin
    if (fwft) begin
      next_flags.empty_flag_n = ~ov;
      next_flags.full_flag_n  = full_pipe[1];
    end else begin
      next_flags.empty_flag_n = empty_pipe[1];
      next_flags.full_flag_n  = ~full_pipe[1];
    end
    next_flags.almost_empty_flag_n =
      (tot > ext(ofs_e) + adj);
    next_flags.half_full_flag_n =
      ~(tot >= HALF + CW'(1) + adj);
    next_flags.almost_full_flag_n =
      ~(tot >= DEP - ext(ofs_f) + adj);
    if (mrs_act) begin
      next_flags.empty_flag_n        = cs.fwft_si;
      next_flags.full_flag_n         = ~cs.fwft_si;
      next_flags.almost_empty_flag_n = 1'b0;
      next_flags.half_full_flag_n    = 1'b1;
      next_flags.almost_full_flag_n  = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wptr] <= din_s;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode          <= DCFF_STD;
      serial_mode   <= 1'b0;
      wptr          <= '0;
      rptr          <= '0;
      mem_cnt       <= '0;
      ov            <= 1'b0;
      ofs_e         <= OFS_PAR_DEF[AW-1:0];
      ofs_f         <= OFS_PAR_DEF[AW-1:0];
      wr_sel        <= 1'b0;
      rd_sel        <= 1'b0;
      empty_pipe    <= 2'h0;
      full_pipe     <= 2'h0;
      read_data_out <= '0;
      flags         <= 5'h0d;
    end else begin
      mode          <= next_mode;
      serial_mode   <= next_serial_mode;
      wptr          <= next_wptr;
      rptr          <= next_rptr;
      mem_cnt       <= next_mem_cnt;
      ov            <= next_ov;
      ofs_e         <= next_ofs_e;
      ofs_f         <= next_ofs_f;
      wr_sel        <= next_wr_sel;
      rd_sel        <= next_rd_sel;
      empty_pipe    <= next_empty_pipe;
      full_pipe     <= next_full_pipe;
      read_data_out <= next_rdata;
      flags         <= next_flags;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_first_load;
    fw_fill ##1 ov;
  endsequence

  sequence s_std_nonempty;
    (mode == DCFF_STD) && empty_pipe[1] && !mrs_act;
  endsequence

  mode_latch_a: assert property (
    mrs_act |=> mode == dcff_mode_t'($past(cs.fwft_si)))
    else $error("timing mode not taken from pin at master reset");

  write_count_a: assert property (
    (do_wr && !mem_rd) |=> mem_cnt == $past(mem_cnt) + 1'b1)
    else $error("write did not raise the word count");

  full_hold_a: assert property (
    (full_mem && !mem_rd && !mrs_act) |=> full_mem && wptr == $past(wptr))
    else $error("write accepted while array full");

  empty_rise_a: assert property (
    s_std_nonempty |=> flags.empty_flag_n)
    else $error("empty flag not raised after data arrived");

  fall_through_a: assert property (
    s_first_load |=> !flags.empty_flag_n)
    else $error("output ready missing after fall-through load");

  empty_ignore_a: assert property (
    (mem_cnt == '0 && !mrs_act) |=> rptr == $past(rptr))
    else $error("read pointer moved on empty array");

  ae_level_a: assert property (
    (!mrs_act && !fwft && ext(ofs_e) >= tot) |=>
      !flags.almost_empty_flag_n)
    else $error("almost-empty high at or below offset");

  half_full_a: assert property (
    (!mrs_act && tot >= HALF + CW'(1) + adj) |=>
      !flags.half_full_flag_n)
    else $error("half-full not low past threshold");

  reset_clear_a: assert property (
    mrs_act [*2] |-> mem_cnt == '0 && !ov && wptr == rptr)
    else $error("master reset left data in the array");

  default_ofs_a: assert property (
    (mrs_act && cs.offset_load_n) |=>
      ofs_e == OFS_SERIAL_DEF[AW-1:0] && serial_mode)
    else $error("serial default offset not set");

endmodule // dcff_core

// ### dcff_peer.sv
`timescale 1ns/100ps

module dcff_peer (
  input  wire logic                        mclk,
  input  wire logic [dcff_pkg::DATA_W-1:0] q_in,
  output logic                             wclk,
  output logic                             rclk,
  output logic                             wen_n,
  output logic                             ren_n,
  output logic                             master_reset_n,
  output logic                             fwft_si,
  output logic                             offset_load_n,
  output logic                             serial_en_n,
  output logic      [dcff_pkg::DATA_W-1:0] data_in
);
  import dcff_pkg::*;

  // ---------------------------------------------------------------
  // producer and consumer of the two link ports
  // ---------------------------------------------------------------
  initial begin
    wclk = 1'b0;
    rclk = 1'b0;
    wen_n = 1'b1;
    ren_n = 1'b1;
    master_reset_n = 1'b1;
    fwft_si = 1'b0;
    offset_load_n = 1'b1;
    serial_en_n = 1'b1;
    data_in = '0;
  end

  // link edges kept off the mclk grid so sampling never races
  initial begin
    #3;
    forever #32 wclk = ~wclk;
  end
  initial begin
    #21;
    forever #32 rclk = ~rclk;
  end

  // controls move only while the link clock is low
  task automatic at_fall(input logic w);
    if (w) @(negedge wclk);
    else @(negedge rclk);
    @(posedge mclk);
  endtask

  task automatic mreset(input logic fw, input logic load);
    @(posedge mclk);
    master_reset_n <= 1'b0;
    fwft_si        <= fw;
    offset_load_n  <= load;
    repeat (8) @(posedge mclk);
    master_reset_n <= 1'b1;
    repeat (6) @(posedge mclk);
    offset_load_n  <= 1'b1;
    fwft_si        <= 1'b0;
  endtask

  task automatic wr(input logic [DATA_W-1:0] d);
    at_fall(1'b1);
    wen_n   <= 1'b0;
    data_in <= d;
    at_fall(1'b1);
    wen_n   <= 1'b1;
    data_in <= ~d;
  endtask

  task automatic rd(output logic [DATA_W-1:0] q);
    at_fall(1'b0);
    ren_n <= 1'b0;
    @(negedge rclk);
    q = q_in;
    @(posedge mclk);
    ren_n <= 1'b1;
  endtask

  // serial shift: empty offset lsb first, full offset msb last
  task automatic ofs_sh(input logic [DATA_W-1:0] e,
                        input logic [DATA_W-1:0] m,
                        input int                n);
    for (int i = 0; i < 2 * n; i++) begin
      at_fall(1'b1);
      offset_load_n <= 1'b0;
      serial_en_n   <= 1'b0;
      fwft_si       <= (i < n) ? e[i] : m[i - n];
    end
    at_fall(1'b1);
    offset_load_n <= 1'b1;
    serial_en_n   <= 1'b1;
    fwft_si       <= 1'b0;
  endtask

  task automatic ofs_wr(input logic [DATA_W-1:0] e,
                        input logic [DATA_W-1:0] m);
    at_fall(1'b1);
    offset_load_n <= 1'b0;
    wen_n         <= 1'b0;
    data_in       <= e;
    at_fall(1'b1);
    data_in       <= m;
    at_fall(1'b1);
    offset_load_n <= 1'b1;
    wen_n         <= 1'b1;
    data_in       <= ~m;
  endtask

  task automatic ofs_rd(output logic [DATA_W-1:0] e,
                        output logic [DATA_W-1:0] m);
    at_fall(1'b0);
    offset_load_n <= 1'b0;
    ren_n         <= 1'b0;
    @(negedge rclk);
    e = q_in;
    @(negedge rclk);
    m = q_in;
    @(posedge mclk);
    offset_load_n <= 1'b1;
    ren_n         <= 1'b1;
  endtask
endmodule // dcff_peer

// ### dcff_core_tb.sv
`timescale 1ns/100ps

module dcff_core_tb;
  import dcff_pkg::*;
  localparam int D = 1024;
  logic              mclk = 1'b0;
  logic              rst_b;
  logic              wclk, rclk, wen_n, ren_n, mrst_n, fwft_si, load_n, sen_n;
  logic [DATA_W-1:0] din, dout, v, w;
  logic [DATA_W-1:0] q[$];
  dcff_flags_t       flags;
  logic              fw;
  int                cnt, ofs_e, ofs_m;
  int                num_errors = 0;
  int                tests_run = 0;

  always #4 mclk = ~mclk;

  dcff_peer peer (.mclk(mclk), .q_in(dout), .wclk(wclk), .rclk(rclk),
    .wen_n(wen_n), .ren_n(ren_n), .master_reset_n(mrst_n),
    .fwft_si(fwft_si), .offset_load_n(load_n), .serial_en_n(sen_n),
    .data_in(din));

  dcff_core #(.DEPTH(D)) dut (.mclk(mclk), .rst_b(rst_b), .wclk(wclk),
    .rclk(rclk), .wen_n(wen_n), .ren_n(ren_n), .master_reset_n(mrst_n),
    .fwft_si(fwft_si), .offset_load_n(load_n), .serial_en_n(sen_n),
    .data_in(din), .read_data_out(dout), .flags(flags));

  // ---------------------------------------------------------------
  // expectations and comparisons
  // ---------------------------------------------------------------
  // fall-through thresholds sit one word higher for the output register
  function automatic dcff_flags_t exp_f(input int c);
    dcff_flags_t f;
    int          k;
    k = fw ? c - 1 : c;
    f.full_flag_n         = fw ^ (k < D);
    f.almost_full_flag_n  = (k < D - ofs_m);
    f.half_full_flag_n    = (k <= D / 2);
    f.almost_empty_flag_n = (k > ofs_e);
    f.empty_flag_n        = fw ^ (c != 0);
    return f;
  endfunction

  function automatic bit cp(input int c);
    int t[13];
    t = '{1, ofs_e, ofs_e + 1, ofs_e + 2, D / 2, D / 2 + 1, D / 2 + 2,
          D - ofs_m - 1, D - ofs_m, D + 1 - ofs_m, D, D + 1, D + 2};
    foreach (t[i]) if (t[i] == c) return 1'b1;
    return 1'b0;
  endfunction

  task automatic chk_d(input string s, input logic [DATA_W-1:0] e,
                       input logic [DATA_W-1:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic chk_f(input string s, input dcff_flags_t e);
    tests_run++;
    if (flags !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %b got %b", s, e, flags);
    end
  endtask

  // flag registers need up to three link edges to follow
  task automatic settle();
    repeat (4) @(negedge rclk);
  endtask

  task automatic put(input int k);
    v = 18'h15a00 + 18'(k);
    peer.wr(v);
    if (cnt < D + int'(fw)) begin
      q.push_back(v);
      cnt++;
    end
  endtask

  task automatic run_mode(input logic fwv, input logic ldv,
                          input logic [15:0] dflt);
    fw = fwv;
    cnt = 0;
    q = {};
    peer.mreset(fwv, ldv);
    settle();
    chk_f("reset flags", exp_f(0));
    peer.ofs_rd(v, w);
    chk_d("empty offset", 18'(dflt), v);
    chk_d("full offset", 18'(dflt), w);
    ofs_e = int'(dflt);
    ofs_m = int'(dflt);
    if (!ldv) begin
      peer.ofs_wr(18'h00064, 18'h000c8);
      ofs_e = 100;
      ofs_m = 200;
      peer.ofs_rd(v, w);
      chk_d("new empty offset", 18'h00064, v);
      chk_d("new full offset", 18'h000c8, w);
    end else begin
      peer.ofs_sh(18'h00096, 18'h000fa, $clog2(D));
      ofs_e = 150;
      ofs_m = 250;
      peer.ofs_rd(v, w);
      chk_d("serial empty offset", 18'h00096, v);
      chk_d("serial full offset", 18'h000fa, w);
    end
    peer.rd(v);
    settle();
    chk_f("read on empty", exp_f(0));
    for (int k = 1; k <= D + 2; k++) begin
      put(k);
      // one read edge after the write the flag stages still show empty
      if (k == 1) begin
        @(negedge rclk);
        chk_f("early flags", exp_f(0));
        settle();
        if (fw) chk_d("fall word", q[0], dout);
      end
      if (cp(k)) begin
        settle();
        chk_f("fill flags", exp_f(cnt));
      end
    end
    while (cnt > 0) begin
      if (fw) chk_d("head word", q[0], dout);
      peer.rd(v);
      if (!fw) chk_d("read word", q[0], v);
      void'(q.pop_front());
      cnt--;
      if (cp(cnt)) begin
        settle();
        chk_f("drain flags", exp_f(cnt));
      end
    end
    settle();
    chk_f("empty again", exp_f(0));
    peer.rd(v);
    put(1);
    settle();
    if (!fw) peer.rd(v);
    else v = dout;
    chk_d("after empty read", q[0], v);
  endtask

  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    run_mode(1'b0, 1'b0, 16'h007f);
    run_mode(1'b1, 1'b1, 16'h03ff);
    complete_run();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    complete_run();
  end
endmodule // dcff_core_tb
